// ===== core/bcs_charger.sv
// Charge phase sequencer, timers and status indication of the charger.
//
// Notes on behaviour
// R1 - Below trickle threshold at cycle start, request one tenth charge current.
// R2 - Trickle lasting over half an hour stops charging, flags bad battery.
// R3 - Above trickle threshold, switch to full constant-current charging.
// R4 - Reaching float voltage holds it and starts the four-hour timer.
// R5 - Safety timer expiry ends the cycle; no further charge current.
// R6 - After termination, a filtered recharge request starts a new cycle.
// R7 - Filtered recharge request while safety timer runs clears it.
// R8 - Recharge request counts only after persisting more than 1.3 ms.
// R9 - Supply lockout or disable cycling restarts cycle and clears timer.
// R10 - Status pin low charging, released idle, carrier on faults.
// R11 - Pin low from charge start, released at float with tenth current.
// R12 - Tenth-current end indication ignored during input current limit.
// R13 - Thermistor fault: slow blink between one and fifteen sixteenths.
// R14 - Bad battery: fast blink between two and fourteen sixteenths.
// R15 - Reader discards a duty reading of exactly one half.
// R16 - Reader may lower load and reset the charger after bad battery.
// R17 - Thermistor hot or cold pauses charging until both are valid.
// R18 - Thermistor pause in float phase also freezes the safety timer.
// R19 - Grounded thermistor input disables temperature pausing.
// R20 - Supply flag sets above rising threshold, clears below falling.
// R21 - All rates and timers are counted from the one clock.
// R22 - Bad battery indication outranks thermistor fault on the pin.
`timescale 1ns/1ps
`default_nettype none
module bcs_charger
  import bcs_pkg::*;
#(
  parameter int unsigned MS_CYC_P   = MS_CYC,   // Clock cycles per ms.
  parameter int unsigned FILT_CYC_P = FILT_CYC, // Recharge filter cycles.
  parameter int unsigned BAD_MS_P   = BAD_MS,   // Trickle limit in ms.
  parameter int unsigned SAFE_MS_P  = SAFE_MS   // Safety timer in ms.
) (
  input  wire logic       ref_clk_in,       // 125 MHz system clock.
  input  wire logic       rst_in,           // Synchronous reset, high.
  input  wire bcs_pkg::bcs_flags_t flags_in, // Raw comparator flags.
  input  wire logic       charger_disable_in, // Serial-port disable bit.
  output logic            chg_en_out,       // Charge current requested.
  output logic            trickle_out,      // Select one tenth current.
  output logic            float_mode_out,   // Constant-voltage phase.
  output logic            bad_batt_out,     // Unresponsive battery fault.
  output logic            ntc_pause_out,    // Paused by temperature.
  output logic            done_out,         // Cycle ended by timer.
  output logic            uvlo_ok_out,      // Input supply qualified.
  output logic            charge_status_pin_out,   // Pin level (0).
  output logic            charge_status_pin_oe_out // Pin pulled low.
);
  import bcs_pkg::*;

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    bcs_state_t       st;
    logic             en_prev;
    logic             uvlo_ok;
    logic [CNT_W-1:0] ms_cnt;
    logic             ms_tick;
    logic [CNT_W-1:0] rchg_cnt;
    logic             filt_hit;
    logic [CNT_W-1:0] bad_cnt;
    logic [CNT_W-1:0] safe_cnt;
    logic             c10_seen;
    logic             chg_en;
    logic             trickle;
    logic             cv;
    logic             bad_batt;
    logic             ntc_pause;
    logic             done;
    bcs_led_t         led;
  } bcs_top_st_t;

  localparam logic [CNT_W-1:0] MS_LAST   = CNT_W'(MS_CYC_P - 1);
  localparam logic [CNT_W-1:0] FILT_N    = CNT_W'(FILT_CYC_P);
  localparam logic [CNT_W-1:0] BAD_LAST  = CNT_W'(BAD_MS_P - 1);
  localparam logic [CNT_W-1:0] SAFE_LAST = CNT_W'(SAFE_MS_P - 1);
  localparam logic [CNT_W-1:0] ONE       = CNT_W'(1);

  bcs_top_st_t q;
  bcs_top_st_t d;
  bcs_flags_t  f;
  logic        enabled;
  logic        fault;
  logic        active;
  logic        pause;

  // ********************************************************************
  // Input synchronisation
  // ********************************************************************
  bcs_sync3 #(
    .W ($bits(bcs_flags_t))
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .async_in   (flags_in),
    .sync_out   (f)
  );

  // Qualified conditions used by the sequencer and the indication.
  assign enabled = q.uvlo_ok & ~charger_disable_in;
  assign fault   = (f.ntc_hot | f.ntc_cold) & ~f.ntc_grounded; // R17 R19
  assign active  = bcs_is_active(q.st);
  assign pause   = fault & active; // R17

  // ********************************************************************
  // Sequencer
  // ********************************************************************
  // Timers run on a shared millisecond tick rather than raw cycles; the
  // hour-scale counts then stay small and a test can shrink the tick.
  always_comb
  begin
    d = q;
    // Supply flag with hysteresis from the two comparators.
    if (f.vbus_rise_ok)
      d.uvlo_ok = 1'b1; // R20
    else if (!f.vbus_fall_ok)
      d.uvlo_ok = 1'b0; // R20
    // Millisecond tick.
    d.ms_tick = 1'b0;
    if (q.ms_cnt == MS_LAST)
    begin
      d.ms_cnt  = '0;
      d.ms_tick = 1'b1; // R21
    end
    else
      d.ms_cnt = q.ms_cnt + ONE;
    // Recharge filter: one pulse per dip that outlasts the interval.
    d.filt_hit = 1'b0;
    if (!f.bat_below_rechg)
      d.rchg_cnt = '0;
    else if (q.rchg_cnt < FILT_N)
      d.rchg_cnt = q.rchg_cnt + ONE;
    else if (q.rchg_cnt == FILT_N)
    begin
      d.rchg_cnt = q.rchg_cnt + ONE;
      d.filt_hit = 1'b1; // R8
    end
    d.en_prev = enabled;
    case (q.st)
      ST_OFF:
      begin
        if (enabled && !q.en_prev)
        begin
          d.st       = ST_TRICKLE; // R9
          d.bad_cnt  = '0;
          d.safe_cnt = '0;         // R9
          d.c10_seen = 1'b0;
        end
      end
      ST_TRICKLE:
      begin
        if (!f.bat_below_trkl)
          d.st = ST_CC; // R3
        else if (q.ms_tick)
        begin
          if (q.bad_cnt >= BAD_LAST)
            d.st = ST_BADBAT; // R2
          else
            d.bad_cnt = q.bad_cnt + ONE;
        end
      end
      ST_CC:
      begin
        if (f.bat_at_float)
        begin
          d.st       = ST_CV; // R4
          d.safe_cnt = '0;    // R4
        end
      end
      ST_CV:
      begin
        if (f.chg_below_c10 && !f.input_ilim)
          d.c10_seen = 1'b1; // R11 R12
        if (q.filt_hit)
          d.safe_cnt = '0; // R7
        else if (q.ms_tick && !pause) // R18
        begin
          if (q.safe_cnt >= SAFE_LAST)
            d.st = ST_DONE; // R5
          else
            d.safe_cnt = q.safe_cnt + ONE;
        end
      end
      ST_DONE:
      begin
        if (q.filt_hit)
        begin
          d.st       = ST_TRICKLE; // R6
          d.bad_cnt  = '0;
          d.safe_cnt = '0;
          d.c10_seen = 1'b0;
        end
      end
      ST_BADBAT:
        d.st = ST_BADBAT; // R2
      default:
        d.st = ST_OFF;
    endcase
    // Losing the supply or the enable parks the charger; the next rising
    // edge of the enable starts a fresh cycle.
    if (!enabled)
      d.st = ST_OFF; // R9
    // Registered outputs.
    d.chg_en    = active & ~pause;          // R1 R5 R17
    d.trickle   = (q.st == ST_TRICKLE);     // R1
    d.cv        = (q.st == ST_CV);          // R4
    d.bad_batt  = (q.st == ST_BADBAT);
    d.ntc_pause = pause;
    d.done      = (q.st == ST_DONE);
    // Bad battery is shown first even if the thermistor is also bad.
    if (q.st == ST_BADBAT)
      d.led = LED_BAD; // R22
    else if (pause)
      d.led = LED_NTC; // R13
    else if (active && !q.c10_seen)
      d.led = LED_CHG; // R11
    else
      d.led = LED_IDLE; // R10
  end

  // State register.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      q     <= '0;
      q.st  <= ST_OFF;
      q.led <= LED_IDLE;
    end
    else
      q <= d;
  end

  // ********************************************************************
  // Status pin
  // ********************************************************************
  bcs_status_pin u_pin (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .ms_tick_in (q.ms_tick),
    .mode_in    (q.led),
    .pin_out    (charge_status_pin_out),
    .pin_oe_out (charge_status_pin_oe_out)
  );

  assign chg_en_out     = q.chg_en;
  assign trickle_out    = q.trickle;
  assign float_mode_out = q.cv;
  assign bad_batt_out   = q.bad_batt;
  assign ntc_pause_out  = q.ntc_pause;
  assign done_out       = q.done;
  assign uvlo_ok_out    = q.uvlo_ok;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_trickle_expire;
    (q.st == ST_TRICKLE) && f.bat_below_trkl && q.ms_tick
      && (q.bad_cnt >= BAD_LAST) && enabled;
  endsequence

  sequence s_restart;
    enabled && !q.en_prev && (q.st == ST_OFF);
  endsequence

  a_trickle_rate: assert property ( // R1
    (q.st == ST_TRICKLE && !pause) |=> chg_en_out && trickle_out)
    else $error("Trickle phase without tenth-rate request.");
  a_bad_entry: assert property ( // R2
    s_trickle_expire |=> (q.st == ST_BADBAT) ##1 bad_batt_out)
    else $error("Trickle timeout did not flag bad battery.");
  a_cc_switch: assert property ( // R3
    (q.st == ST_TRICKLE && !f.bat_below_trkl && enabled)
      |=> (q.st == ST_CC))
    else $error("Trickle did not end above threshold.");
  a_float_start: assert property ( // R4
    (q.st == ST_CC && f.bat_at_float && enabled)
      |=> (q.st == ST_CV) && (q.safe_cnt == '0))
    else $error("Float entry did not start the safety timer.");
  a_done_off: assert property ( // R5
    (q.st == ST_DONE) |=> !chg_en_out)
    else $error("Charge current after termination.");
  a_recharge: assert property ( // R6
    (q.st == ST_DONE && q.filt_hit && enabled) |=> (q.st == ST_TRICKLE))
    else $error("Recharge request did not restart the cycle.");
  a_timer_clear: assert property ( // R7
    (q.st == ST_CV && q.filt_hit && enabled) |=> (q.safe_cnt == '0))
    else $error("Recharge request did not clear the safety timer.");
  a_filter_len: assert property ( // R8
    q.filt_hit |-> $past(f.bat_below_rechg, 2)
      && (q.rchg_cnt == FILT_N + ONE))
    else $error("Recharge filter fired early.");
  a_restart: assert property ( // R9
    s_restart |=> (q.st == ST_TRICKLE) && (q.safe_cnt == '0))
    else $error("Enable cycle did not restart charging.");
  a_ntc_pause: assert property ( // R17
    pause |=> !chg_en_out && ntc_pause_out)
    else $error("Charging continued during thermistor fault.");
  a_timer_freeze: assert property ( // R18
    (q.st == ST_CV && pause && enabled && !q.filt_hit)
      |=> (q.safe_cnt == $past(q.safe_cnt)))
    else $error("Safety timer ran during thermistor pause.");
  a_ntc_ground: assert property ( // R19
    (f.ntc_grounded && active) |=> !ntc_pause_out)
    else $error("Grounded thermistor still paused charging.");
  a_bad_priority: assert property ( // R22
    (q.st == ST_BADBAT) |=> (q.led == LED_BAD))
    else $error("Bad battery indication lost priority.");
endmodule : bcs_charger
`default_nettype wire

// ===== core/bcs_pkg.sv
// Shared constants, types and helpers of the battery charge sequencer.
package bcs_pkg;

  // ********************************************************************
  // Clock and time figures
  // ********************************************************************
  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned CLK_MHZ        = CLK_HZ / 1_000_000;
  localparam int unsigned CNT_W          = 32;
  localparam int unsigned MS_PER_S       = 1000;
  localparam int unsigned BAD_BATT_MIN   = 30;
  localparam int unsigned SAFETY_HR      = 4;
  localparam int unsigned RECHG_FILT_NS  = 1_300_000;
  localparam int unsigned CARRIER_HZ     = 35_000;
  localparam int unsigned SLOW_BLINK_MHZ = 1500;
  localparam int unsigned FAST_BLINK_MHZ = 6100;

  // Cycle, millisecond and slot counts derived from the figures above.
  localparam int unsigned MS_CYC     = CLK_HZ / MS_PER_S;
  localparam int unsigned BAD_MS     = BAD_BATT_MIN * 60 * MS_PER_S;
  localparam int unsigned SAFE_MS    = SAFETY_HR * 3600 * MS_PER_S;
  localparam int unsigned FILT_CYC   = (RECHG_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DUTY_SLOTS = 16;
  localparam int unsigned SLOT_CYC   = CLK_HZ / (CARRIER_HZ * DUTY_SLOTS);
  localparam int unsigned SLOW_HALF_MS = 1_000_000 / (2 * SLOW_BLINK_MHZ);
  localparam int unsigned FAST_HALF_MS = 1_000_000 / (2 * FAST_BLINK_MHZ);

  // ********************************************************************
  // Duty cycles in sixteenths of a carrier period, pin pulled low
  // ********************************************************************
  localparam logic [3:0] DUTY_NTC_LO = 4'h1;
  localparam logic [3:0] DUTY_NTC_HI = 4'hf;
  localparam logic [3:0] DUTY_BAD_LO = 4'h2;
  localparam logic [3:0] DUTY_BAD_HI = 4'he;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [5:0] {
    ST_OFF     = 6'h01,
    ST_TRICKLE = 6'h02,
    ST_CC      = 6'h04,
    ST_CV      = 6'h08,
    ST_DONE    = 6'h10,
    ST_BADBAT  = 6'h20
  } bcs_state_t;

  typedef enum logic [3:0] {
    LED_IDLE = 4'h1,
    LED_CHG  = 4'h2,
    LED_NTC  = 4'h4,
    LED_BAD  = 4'h8
  } bcs_led_t;

  // Comparator flags from the analog charger, all asynchronous.
  typedef struct packed {
    logic vbus_rise_ok;
    logic vbus_fall_ok;
    logic bat_below_trkl;
    logic bat_at_float;
    logic bat_below_rechg;
    logic chg_below_c10;
    logic input_ilim;
    logic ntc_hot;
    logic ntc_cold;
    logic ntc_grounded;
  } bcs_flags_t;

  // True in the phases that deliver charge current.
  function automatic logic bcs_is_active(input bcs_state_t st);
    bcs_is_active = (st == ST_TRICKLE) || (st == ST_CC) || (st == ST_CV);
  endfunction : bcs_is_active

endpackage : bcs_pkg

// ===== core/bcs_status_pin.sv
// Open-drain charge status pin: steady levels and blinking fault carrier.
`timescale 1ns/1ps
`default_nettype none
module bcs_status_pin
  import bcs_pkg::*;
(
  input  wire logic      ref_clk_in, // System clock.
  input  wire logic      rst_in,     // Synchronous reset, high.
  input  wire logic      ms_tick_in, // One-cycle millisecond pulse.
  input  wire bcs_pkg::bcs_led_t mode_in, // Indication to show.
  output logic           pin_out,    // Pin level when driven (always 0).
  output logic           pin_oe_out  // High while the pin is pulled low.
);
  typedef struct packed {
    logic       oe;
    logic [7:0] slot_cnt;
    logic [3:0] slot_idx;
    logic [9:0] blink_cnt;
    logic       phase;
    bcs_led_t   mode_prev;
  } bcs_pin_st_t;

  localparam logic [7:0] SLOT_LAST  = 8'(SLOT_CYC - 1);
  localparam logic [9:0] SLOW_LAST  = 10'(SLOW_HALF_MS - 1);
  localparam logic [9:0] FAST_LAST  = 10'(FAST_HALF_MS - 1);

  bcs_pin_st_t q;
  bcs_pin_st_t d;
  logic [3:0]  duty;
  logic [9:0]  half_last;

  // Carrier slots, blink phase and pin level. A mode change restarts the
  // blink so that each fault starts on a full half period.
  always_comb
  begin
    d           = q;
    d.mode_prev = mode_in;
    half_last   = (mode_in == LED_NTC) ? SLOW_LAST : FAST_LAST;
    if (q.slot_cnt == SLOT_LAST)
    begin
      d.slot_cnt = 8'h00;
      d.slot_idx = q.slot_idx + 4'h1;
    end
    else
      d.slot_cnt = q.slot_cnt + 8'h01;
    if (mode_in != q.mode_prev)
    begin
      d.blink_cnt = 10'h000;
      d.phase     = 1'b0;
    end
    else if (ms_tick_in)
    begin
      if (q.blink_cnt >= half_last)
      begin
        d.blink_cnt = 10'h000;
        d.phase     = ~q.phase; // R13 R14
      end
      else
        d.blink_cnt = q.blink_cnt + 10'h001;
    end
    case (mode_in)
      LED_NTC: duty = q.phase ? DUTY_NTC_HI : DUTY_NTC_LO; // R13
      LED_BAD: duty = q.phase ? DUTY_BAD_HI : DUTY_BAD_LO; // R14
      default: duty = 4'h0;
    endcase
    case (mode_in)
      LED_CHG:  d.oe = 1'b1;                    // R10 R11
      LED_IDLE: d.oe = 1'b0;                    // R10 R11
      default:  d.oe = (q.slot_idx < duty);     // R10
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      q           <= '0;
      q.mode_prev <= LED_IDLE;
    end
    else
      q <= d;
  end

  assign pin_out    = 1'b0;
  assign pin_oe_out = q.oe;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  a_charging_low: assert property ( // R11
    (mode_in == LED_CHG) |=> pin_oe_out)
    else $error("Status pin not low while charging.");
  a_idle_release: assert property ( // R10
    (mode_in == LED_IDLE) |=> !pin_oe_out)
    else $error("Status pin driven while not charging.");
  a_ntc_duty_off: assert property ( // R13
    (mode_in == LED_NTC && q.slot_idx == DUTY_NTC_HI) |=> !pin_oe_out)
    else $error("Thermistor carrier exceeds high duty.");
  a_bad_duty_on: assert property ( // R14
    (mode_in == LED_BAD && q.slot_idx == 4'h0) |=> pin_oe_out)
    else $error("Bad battery carrier lost its low part.");
endmodule : bcs_status_pin
`default_nettype wire

// ===== core/bcs_sync3.sv
// Three-stage synchroniser with agreement filter for asynchronous flags.
`timescale 1ns/1ps
`default_nettype none
module bcs_sync3 #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk_in, // System clock.
  input  wire logic         rst_in,     // Synchronous reset, high.
  input  wire logic [W-1:0] async_in,   // Raw asynchronous levels.
  output logic      [W-1:0] sync_out    // Filtered synchronous levels.
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } bcs_sync_st_t;

  bcs_sync_st_t q;
  bcs_sync_st_t d;

  // A bit changes only where the second and third stages agree, so a
  // single metastable sample can never reach the charger logic.
  always_comb
  begin
    d    = q;
    d.s1 = async_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.q  = (q.q & (q.s2 ^ q.s3)) | (q.s3 & ~(q.s2 ^ q.s3));
  end

  // State register.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      q <= '0;
    else
      q <= d;
  end

  assign sync_out = q.q;
endmodule : bcs_sync3
`default_nettype wire

// ===== verif/bcs_batt_model.sv
// Cell, comparator and pulled-up status line model for the charger.
`timescale 1ns/1ps
`default_nettype none
module bcs_batt_model
  import bcs_pkg::*;
(
  input  wire logic               ref_clk_in, // System clock.
  input  wire logic               chg_en_in,  // Charge current requested.
  input  wire logic               trickle_in, // Tenth current selected.
  input  wire logic               pin_in,     // Pin level when driven.
  input  wire logic               pin_oe_in,  // Pin pulled low.
  input  wire logic               vbus_in,    // Supply present.
  input  wire logic               stuck_in,   // Cell refuses charge.
  input  wire logic               drain_in,   // Cell self-discharges.
  input  wire logic               dip_in,     // Sag below recharge level.
  input  wire logic               hot_in,     // Cell too hot.
  input  wire logic               cold_in,    // Cell too cold.
  input  wire logic               gnd_in,     // Sensor input grounded.
  input  wire logic               ilim_in,    // Input current limited.
  output var bcs_pkg::bcs_flags_t flags_out,  // Comparator flags.
  output logic                    level_out   // Resolved pin level.
);
  int unsigned mv_q  = 2000;
  int unsigned flt_q = 0;
  int unsigned step;

  // Cell voltage in mV; coarse steps keep each phase tens of cycles long.
  always @(posedge ref_clk_in)
  begin
    step = trickle_in ? 50 : 20;
    if (drain_in && mv_q > 0)
      mv_q <= mv_q - 1;
    else if (chg_en_in && !stuck_in)
      mv_q <= (mv_q + step > 4200) ? 4200 : mv_q + step;
    flt_q <= (chg_en_in && mv_q == 4200) ? flt_q + 1 : 0;
  end

  // Current tapers to a tenth only some cycles after float is reached.
  always_comb
  begin
    flags_out.vbus_rise_ok    = vbus_in;
    flags_out.vbus_fall_ok    = vbus_in;
    flags_out.bat_below_trkl  = mv_q < 2850;
    flags_out.bat_at_float    = mv_q >= 4200;
    flags_out.bat_below_rechg = (mv_q < 4100) || dip_in;
    flags_out.chg_below_c10   = flt_q >= 16;
    flags_out.input_ilim      = ilim_in;
    flags_out.ntc_hot         = hot_in;
    flags_out.ntc_cold        = cold_in;
    flags_out.ntc_grounded    = gnd_in;
  end

  // Released line goes to the pull-up level, never the last driven value.
  assign level_out = pin_oe_in ? pin_in : 1'b1;
endmodule : bcs_batt_model
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking testbench of the battery charge sequencer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bcs_pkg::*;
  localparam int unsigned MS   = 10;
  localparam int unsigned FILT = 20;
  localparam int unsigned BAD  = 5;
  localparam int unsigned SAFE = 20;
  logic       ref_clk = 1'b0, rst = 1'b1, dis = 1'b0;
  logic       vbus = 1'b0, stuck = 1'b0, drain = 1'b0, dip = 1'b0;
  logic       hot = 1'b0, cold = 1'b0, gnd = 1'b0, ilim = 1'b0;
  bcs_flags_t flags;
  logic       chg_en, trickle, float_mode, bad_batt, pause, done, uvlo_ok;
  logic       pin, pin_oe, level;
  int         n_mismatch = 0;
  int         tests_run = 0;
  bit         seen;

  bcs_charger #(
    .MS_CYC_P  (MS),
    .FILT_CYC_P(FILT),
    .BAD_MS_P  (BAD),
    .SAFE_MS_P (SAFE)
  ) i_bcs_charger (
    .ref_clk_in              (ref_clk),
    .rst_in                  (rst),
    .flags_in                (flags),
    .charger_disable_in      (dis),
    .chg_en_out              (chg_en),
    .trickle_out             (trickle),
    .float_mode_out          (float_mode),
    .bad_batt_out            (bad_batt),
    .ntc_pause_out           (pause),
    .done_out                (done),
    .uvlo_ok_out             (uvlo_ok),
    .charge_status_pin_out   (pin),
    .charge_status_pin_oe_out(pin_oe)
  );

  bcs_batt_model i_bcs_batt_model (
    .ref_clk_in(ref_clk),
    .chg_en_in (chg_en),
    .trickle_in(trickle),
    .pin_in    (pin),
    .pin_oe_in (pin_oe),
    .vbus_in   (vbus),
    .stuck_in  (stuck),
    .drain_in  (drain),
    .dip_in    (dip),
    .hot_in    (hot),
    .cold_in   (cold),
    .gnd_in    (gnd),
    .ilim_in   (ilim),
    .flags_out (flags),
    .level_out (level)
  );

  // ********************************************************************
  // Clock, checking and closing
  // ********************************************************************
  // Free-running 125 MHz clock.
  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  // Looks for a pulse or gap of exactly len cycles; a reading blended
  // across a blink edge never has that length, so it is passed over.
  task automatic blink(input int n, input int len, output bit hit);
    int   run;
    logic last;
    run = 0;
    last = level;
    hit = 0;
    repeat (n)
    begin
      @(posedge ref_clk);
      if (level === last)
        run++;
      else
      begin
        hit = hit | (run == len);
        run = 1;
        last = level;
      end
    end
  endtask : blink

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic t_bad_cell;
    @(posedge ref_clk);
    stuck <= 1'b1;
    vbus <= 1'b1;
    for (int i = 0; i < 40 && chg_en !== 1'b1; i++) @(posedge ref_clk);
    chk(chg_en, 1'b1);
    chk(trickle, 1'b1);
    chk(uvlo_ok, 1'b1);
    repeat (BAD * MS - 10) @(posedge ref_clk);
    chk(bad_batt, 1'b0);
    chk(level, 1'b0);
    for (int i = 0; i < 40 && bad_batt !== 1'b1; i++) @(posedge ref_clk);
    chk(bad_batt, 1'b1);
    chk(chg_en, 1'b0);
    blink(30000, 2 * SLOT_CYC, seen);
    chk(seen, 1'b1);
    hot <= 1'b1;
    blink(15000, 2 * SLOT_CYC, seen);
    chk(seen, 1'b1);
    hot <= 1'b0;
    stuck <= 1'b0;
    dis <= 1'b1;
    repeat (5) @(posedge ref_clk);
    dis <= 1'b0;
    for (int i = 0; i < 40 && chg_en !== 1'b1; i++) @(posedge ref_clk);
    chk(chg_en, 1'b1);
    chk(bad_batt, 1'b0);
  endtask : t_bad_cell

  task automatic t_full_cycle;
    ilim <= 1'b1;
    for (int i = 0; i < 100 && trickle !== 1'b0; i++) @(posedge ref_clk);
    chk(trickle, 1'b0);
    chk(chg_en, 1'b1);
    for (int i = 0; i < 150 && float_mode !== 1'b1; i++) @(posedge ref_clk);
    chk(float_mode, 1'b1);
    repeat (40) @(posedge ref_clk);
    chk(level, 1'b0);
    ilim <= 1'b0;
    dip <= 1'b1;
    repeat (FILT / 2) @(posedge ref_clk);
    dip <= 1'b0;
    repeat (20) @(posedge ref_clk);
    chk(level, 1'b1);
    chk(done, 1'b0);
    for (int i = 0; i < 160 && done !== 1'b1; i++) @(posedge ref_clk);
    chk(done, 1'b1);
    chk(chg_en, 1'b0);
  endtask : t_full_cycle

  task automatic t_recharge;
    drain <= 1'b1;
    for (int i = 0; i < 200 && chg_en !== 1'b1; i++) @(posedge ref_clk);
    chk(chg_en, 1'b1);
    drain <= 1'b0;
    for (int i = 0; i < 150 && float_mode !== 1'b1; i++) @(posedge ref_clk);
    hot <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(pause, 1'b1);
    chk(chg_en, 1'b0);
    blink(10000, SLOT_CYC, seen);
    chk(seen, 1'b1);
    chk(done, 1'b0);
    hot <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk(chg_en, 1'b1);
    repeat (100) @(posedge ref_clk);
    dip <= 1'b1;
    repeat (FILT * 2) @(posedge ref_clk);
    dip <= 1'b0;
    repeat (130) @(posedge ref_clk);
    chk(done, 1'b0);
    for (int i = 0; i < 150 && done !== 1'b1; i++) @(posedge ref_clk);
    chk(done, 1'b1);
  endtask : t_recharge

  task automatic t_grounded;
    gnd <= 1'b1;
    cold <= 1'b1;
    drain <= 1'b1;
    for (int i = 0; i < 200 && chg_en !== 1'b1; i++) @(posedge ref_clk);
    drain <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk(chg_en, 1'b1);
    chk(pause, 1'b0);
    // Supply loss parks the charger; its return starts a fresh cycle.
    vbus <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk(uvlo_ok, 1'b0);
    chk(chg_en, 1'b0);
    vbus <= 1'b1;
    for (int i = 0; i < 40 && chg_en !== 1'b1; i++) @(posedge ref_clk);
    chk(chg_en, 1'b1);
    repeat (2) @(posedge ref_clk);
    chk(level, 1'b0);
  endtask : t_grounded

  // Main sequence; each scenario leaves the charger where the next starts.
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_bad_cell();
    t_full_cycle();
    t_recharge();
    t_grounded();
    stop_test();
  end

  // Watchdog well beyond the roughly 57000 cycles the scenarios need.
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    n_mismatch++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
